// ==== test/adcoc_regs_tb.sv ====
// testbench for the output config register bank
`timescale 1ns/10ps
`default_nettype none
module adcoc_regs_tb;
	logic clk_in = 0, arst_n_in = 0, src = 0, pen = 0, lvds = 0, done = 0, vld = 0;
	adcoc_pkg::adcoc_bus_req_t bus = '0;
	logic [8:0] fa = 9'h000;
	logic [7:0] fb = 8'h00, rdata;
	logic [2:0] tsel = 3'h0, psel;
	logic [11:0] patb = 12'h123, smp = 12'h000, dout, rxw;
	logic [5:0] inv;
	logic [3:0] vdly, tpins;
	logic [15:0] rxc;
	logic pden, finv, fen, pulse, busy, gate;
	int fails = 0, tests_run = 0, cyc = 0;
	adcoc_regs uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus), .rdata_out(rdata),
		.decim_filter_first_in(fa), .decim_filter_quadrature_in(fb), .pll_is_source_in(src),
		.pll_enable_in(pen), .lvds_mode_in(lvds), .pll_cal_done_in(done), .test_pattern_sel_in(tsel),
		.pattern_b_in(patb), .sample_in(smp), .sample_valid_in(vld), .data_out(dout),
		.phase_delay_enable_out(pden), .decim_outclk_phase_sel_out(psel), .lvds_pair_invert_out(inv),
		.flag_pair_invert_out(finv), .flag_pair_enable_out(fen), .synth_recal_pulse_out(pulse),
		.pll_cal_busy_out(busy), .pll_clk_gate_out(gate), .vco_cycle_outclk_delay_out(vdly),
		.unused_test_pins_out(tpins));
	adcoc_rx_model rx (.clk_in(clk_in), .arst_n_in(arst_n_in), .data_in(dout), .flag_en_in(fen),
		.word_out(rxw), .count_out(rxc));
	initial forever #50 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			results();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_in) bus <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_in) bus <= '0;
		#1 chk("rdata", {8'h00, e}, {8'h00, rdata});
	endtask : rd
	task automatic samp(input logic [11:0] s, input logic [11:0] e);
		@(posedge clk_in) begin
			smp <= s;
			vld <= 1'b1;
		end
		@(posedge clk_in) vld <= 1'b0;
		#1 chk("data_out", {4'h0, e}, {4'h0, dout});
	endtask : samp
	task automatic t_reset;
		rd(8'h64, 8'h03);
		@(posedge clk_in) #1 chk("rdata_idle", 16'h0000, {8'h00, rdata});
		rd(8'h65, 8'h00);
		rd(8'h66, 8'h00);
		rd(8'h67, 8'h00);
		rd(8'h68, 8'h24);
		rd(8'h6B, 8'h08);
		rd(8'h6D, 8'h00);
		rd(8'h74, 8'h00);
		rd(8'h75, 8'h00);
		rd(8'h70, 8'h00);
		chk("flag_en", 16'h0001, {15'h0, fen});
		chk("gate", 16'h0000, {15'h0, gate});
	endtask : t_reset
	task automatic t_phase;
		@(posedge clk_in) fa <= 9'h006;
		wr(8'h64, 8'h23);
		chk("phase_off", 16'h0000, {13'h0, psel});
		wr(8'h64, 8'hA3);
		chk("phase_en", 16'h0001, {15'h0, pden});
		chk("phase_2", 16'h0002, {13'h0, psel});
		wr(8'h64, 8'h83);
		chk("phase_ref", 16'h0000, {13'h0, psel});
		wr(8'h64, 8'hF3);
		chk("phase_7", 16'h0007, {13'h0, psel});
		@(posedge clk_in) fa <= 9'h000;
		wr(8'h64, 8'hC3);
		chk("phase_odd", 16'h0005, {13'h0, psel});
		wr(8'h64, 8'h83);
		chk("phase_odd0", 16'h0001, {13'h0, psel});
	endtask : t_phase
	task automatic t_pol_flag;
		wr(8'h65, 8'h80);
		chk("pol_msb", 16'h0020, {10'h0, inv});
		wr(8'h65, 8'h07);
		chk("pol_lsb", 16'h0001, {10'h0, inv});
		wr(8'h68, 8'h28);
		chk("finv_cmos", 16'h0000, {15'h0, finv});
		chk("fen_off", 16'h0000, {15'h0, fen});
		@(posedge clk_in) lvds <= 1'b1;
		#1 chk("finv_lvds", 16'h0001, {15'h0, finv});
	endtask : t_pol_flag
	task automatic t_recal;
		wr(8'h6B, 8'h0C);
		chk("pulse", 16'h0001, {15'h0, pulse});
		chk("busy", 16'h0001, {15'h0, busy});
		@(posedge clk_in) #1 chk("pulse_end", 16'h0000, {15'h0, pulse});
		rd(8'hD1, 8'h01);
		wr(8'h6B, 8'h0C);
		chk("no_pulse", 16'h0000, {15'h0, pulse});
		@(posedge clk_in) done <= 1;
		@(posedge clk_in) done <= 0;
		rd(8'hD1, 8'h00);
		chk("busy_clr", 16'h0000, {15'h0, busy});
		wr(8'h6B, 8'h08);
		chk("pulse_fall", 16'h0001, {15'h0, pulse});
	endtask : t_recal
	task automatic t_pll;
		wr(8'h6D, 8'hEE);
		rd(8'h6D, 8'h2E);
		chk("gate_nosrc", 16'h0000, {15'h0, gate});
		@(posedge clk_in) src <= 1'b1;
		#1 chk("gate_nopen", 16'h0000, {15'h0, gate});
		@(posedge clk_in) pen <= 1'b1;
		wr(8'h6D, 8'h2E);
		chk("gate", 16'h0001, {15'h0, gate});
		chk("vco15", 16'h000F, {12'h0, vdly});
		wr(8'h6D, 8'h2C);
		chk("vco14", 16'h000E, {12'h0, vdly});
		wr(8'h6D, 8'h22);
		chk("vco1", 16'h0001, {12'h0, vdly});
		@(posedge clk_in) fa <= 9'h001;
		#1 chk("vco_decim", 16'h0000, {12'h0, vdly});
	endtask : t_pll
	task automatic t_offset;
		samp(12'h064, 12'h064);
		wr(8'h66, 8'h04);
		samp(12'h064, 12'h065);
		wr(8'h67, 8'hFF);
		wr(8'h66, 8'hF8);
		samp(12'h064, 12'h062);
		wr(8'h67, 8'h80);
		wr(8'h66, 8'h00);
		samp(12'h064, 12'h800);
		wr(8'h67, 8'h7F);
		samp(12'h7FF, 12'h7FF);
	endtask : t_offset
	task automatic t_pattern;
		wr(8'h74, 8'hA0);
		wr(8'h75, 8'h5B);
		chk("tpins", 16'h0000, {12'h0, tpins});
		wr(8'h68, 8'h24);
		@(posedge clk_in) tsel <= 3'h1;
		samp(12'h000, 12'h5BA);
		samp(12'h000, 12'h123);
		samp(12'h000, 12'h5BA);
		@(posedge clk_in) #1 chk("rx_word", 16'h05BA, {4'h0, rxw});
		chk("rx_count", 16'h0003, rxc);
	endtask : t_pattern
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (16) @(posedge clk_in);
		arst_n_in <= 1;
		t_reset();
		t_phase();
		t_pol_flag();
		t_recal();
		t_pll();
		t_offset();
		t_pattern();
		results();
	end
endmodule : adcoc_regs_tb
`default_nettype wire

// ==== test/adcoc_rx_model.sv ====
// host receiver model: captures output words as they arrive
`timescale 1ns/10ps
`default_nettype none
module adcoc_rx_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	// captured word, flag enable and word count
	input  wire logic [11:0] data_in,
	input  wire logic        flag_en_in,
	output logic [11:0]      word_out,
	output logic [15:0]      count_out
);
	logic [11:0] word_q;
	logic [15:0] count_q;
	logic [11:0] last_q;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			word_q  <= 12'h000;
			count_q <= 16'h0000;
			last_q  <= 12'h000;
		end else begin
			// new word counted only when the value moves
			word_q <= data_in;
			last_q <= data_in;
			if (data_in != last_q && flag_en_in)
				count_q <= count_q + 16'h0001;
		end
	end
	assign word_out  = word_q;
	assign count_out = count_q;
endmodule : adcoc_rx_model
`default_nettype wire

// ==== verilog/adcoc_pkg.sv ====
// package: register map, reset values and carriers for the output config bank
package adcoc_pkg;
	localparam logic [7:0] DECIM_CLOCK_PHASE_CTRL_OFS = 8'h64;
	localparam logic [7:0] LVDS_PAIR_POLARITY_OFS     = 8'h65;
	localparam logic [7:0] DIGITAL_OFFSET_LOW_OFS     = 8'h66;
	localparam logic [7:0] DIGITAL_OFFSET_HIGH_OFS    = 8'h67;
	localparam logic [7:0] OVERRANGE_WORDCLK_CTRL_OFS = 8'h68;
	localparam logic [7:0] PLL_RECALIBRATION_OFS      = 8'h6B;
	localparam logic [7:0] PLL_OUTPUT_CLOCK_PHASE_OFS = 8'h6D;
	localparam logic [7:0] USER_PATTERN_A_LOW_OFS     = 8'h74;
	localparam logic [7:0] USER_PATTERN_A_HIGH_OFS    = 8'h75;
	localparam logic [7:0] PLL_CAL_STATUS_OFS         = 8'hD1;
	// reset values and PLL output phase write mask
	localparam logic [7:0] DECIM_CLOCK_PHASE_CTRL_RST = 8'h03;
	localparam logic [7:0] OVERRANGE_WORDCLK_CTRL_RST = 8'h24;
	localparam logic [7:0] PLL_RECALIBRATION_RST      = 8'h08;
	localparam logic [7:0] ZERO_RST                   = 8'h00;
	localparam logic [7:0] PLL_OUTPUT_PHASE_MASK      = 8'h3F;
	// field positions and test pattern select code
	localparam int PHASE_EN_BIT   = 7;
	localparam int PHASE_SEL_LSB  = 4;
	localparam int POL_LSB        = 2;
	localparam int FLAG_INV_BIT   = 3;
	localparam int FLAG_EN_BIT    = 2;
	localparam int RECAL_BIT      = 2;
	localparam int PLL_CLK_EN_BIT = 5;
	localparam int VCO_DLY_LSB    = 1;
	localparam int PAT_LOW_LSB    = 4;
	localparam int CAL_BUSY_BIT   = 0;
	localparam logic [2:0] TEST_SEL_PATTERN_AB = 3'h1;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} adcoc_bus_req_t;

	typedef struct packed {
		logic [7:0]  phase_ctrl;
		logic [7:0]  polarity;
		logic [7:0]  offset_low;
		logic [7:0]  offset_high;
		logic [7:0]  flag_ctrl;
		logic [7:0]  recal;
		logic [7:0]  pll_out;
		logic [7:0]  pat_a_low;
		logic [7:0]  pat_a_high;
		logic        cal_busy;
		logic        recal_pulse;
		logic        alt_sel;
		logic [11:0] data;
		logic [7:0]  rdata;
	} adcoc_state_t;
endpackage : adcoc_pkg

// ==== verilog/adcoc_regs.sv ====
// module: output path configuration register bank with offset and pattern path
`timescale 1ns/10ps
`default_nettype none
module adcoc_regs #(
	parameter int SAMPLE_W = 12
) (
	// clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       arst_n_in,
	// register port
	input  wire adcoc_pkg::adcoc_bus_req_t  bus_in,
	output logic [7:0]                      rdata_out,
	// decimation and clocking context
	input  wire logic [8:0]                 decim_filter_first_in,
	input  wire logic [7:0]                 decim_filter_quadrature_in,
	input  wire logic                       pll_is_source_in,
	input  wire logic                       pll_enable_in,
	input  wire logic                       lvds_mode_in,
	input  wire logic                       pll_cal_done_in,
	// sample path
	input  wire logic [2:0]                 test_pattern_sel_in,
	input  wire logic [11:0]                pattern_b_in,
	input  wire logic signed [SAMPLE_W-1:0] sample_in,
	input  wire logic                       sample_valid_in,
	output logic [SAMPLE_W-1:0]             data_out,
	// output control
	output logic                            phase_delay_enable_out,
	output logic [2:0]                      decim_outclk_phase_sel_out,
	output logic [5:0]                      lvds_pair_invert_out,
	output logic                            flag_pair_invert_out,
	output logic                            flag_pair_enable_out,
	output logic                            synth_recal_pulse_out,
	output logic                            pll_cal_busy_out,
	output logic                            pll_clk_gate_out,
	output logic [3:0]                      vco_cycle_outclk_delay_out,
	output logic [3:0]                      unused_test_pins_out
);
	adcoc_pkg::adcoc_state_t q, d;
	logic                    decim_gt2;
	logic                    decim_none;
	logic                    pll_ready;
	logic [2:0]              phase_code;
	logic [2:0]              vco_code;
	logic [11:0]             pattern_a;
	logic signed [17:0]      sum;
	logic                    wr_recal;

	// decimation rate above two or none at all
	assign decim_gt2  = (|decim_filter_first_in[8:1]) | (|decim_filter_quadrature_in[7:1]);
	assign decim_none = (decim_filter_first_in == 9'h000) && (decim_filter_quadrature_in == 8'h00);
	assign pll_ready  = pll_is_source_in & pll_enable_in;

	// clock phase selection
	assign phase_delay_enable_out = q.phase_ctrl[adcoc_pkg::PHASE_EN_BIT];
	assign phase_code = q.phase_ctrl[adcoc_pkg::PHASE_SEL_LSB +: 3];
	always_comb begin
		if (!phase_delay_enable_out) begin
			decim_outclk_phase_sel_out = 3'h0;
		end else if (decim_gt2) begin
			decim_outclk_phase_sel_out = phase_code;
		end else begin
			decim_outclk_phase_sel_out = phase_code | 3'h1;
		end
	end

	// pair polarity and flag pair
	assign lvds_pair_invert_out = q.polarity[adcoc_pkg::POL_LSB +: 6];
	assign flag_pair_invert_out = q.flag_ctrl[adcoc_pkg::FLAG_INV_BIT] & lvds_mode_in;
	assign flag_pair_enable_out = q.flag_ctrl[adcoc_pkg::FLAG_EN_BIT];

	// PLL clock gating and VCO delay
	assign pll_clk_gate_out = q.pll_out[adcoc_pkg::PLL_CLK_EN_BIT] & pll_ready;
	assign vco_code = q.pll_out[adcoc_pkg::VCO_DLY_LSB +: 3];
	always_comb begin
		if (!(pll_ready && decim_none)) begin
			vco_cycle_outclk_delay_out = 4'h0;
		end else if (vco_code < 3'h6) begin
			vco_cycle_outclk_delay_out = {1'b0, vco_code};
		end else begin
			vco_cycle_outclk_delay_out = {1'b1, vco_code};
		end
	end

	// recalibration and pattern assembly
	assign synth_recal_pulse_out = q.recal_pulse;
	assign pll_cal_busy_out      = q.cal_busy;
	assign pattern_a = {q.pat_a_high, q.pat_a_low[adcoc_pkg::PAT_LOW_LSB +: 4]};
	assign unused_test_pins_out = q.pat_a_low[3:0];
	assign wr_recal = bus_in.wr && (bus_in.addr == adcoc_pkg::PLL_RECALIBRATION_OFS);
	assign rdata_out = q.rdata;
	assign data_out  = q.data;

	// offset in quarter LSb added to sample
	assign sum = 18'($signed({sample_in, 2'b00})) + 18'($signed({q.offset_high, q.offset_low}));

	always_comb begin
		d = q;
		d.rdata = 8'h00;
		// writes store whole bytes, factory bits included, except PLL output phase, masked to bits 5:0
		if (bus_in.wr) begin
			if (bus_in.addr == adcoc_pkg::DECIM_CLOCK_PHASE_CTRL_OFS) begin
				d.phase_ctrl = bus_in.wdata;
			end else if (bus_in.addr == adcoc_pkg::LVDS_PAIR_POLARITY_OFS) begin
				d.polarity = bus_in.wdata;
			end else if (bus_in.addr == adcoc_pkg::DIGITAL_OFFSET_LOW_OFS) begin
				d.offset_low = bus_in.wdata;
			end else if (bus_in.addr == adcoc_pkg::DIGITAL_OFFSET_HIGH_OFS) begin
				d.offset_high = bus_in.wdata;
			end else if (bus_in.addr == adcoc_pkg::OVERRANGE_WORDCLK_CTRL_OFS) begin
				d.flag_ctrl = bus_in.wdata;
			end else if (bus_in.addr == adcoc_pkg::PLL_RECALIBRATION_OFS) begin
				d.recal = bus_in.wdata;
			end else if (bus_in.addr == adcoc_pkg::PLL_OUTPUT_CLOCK_PHASE_OFS) begin
				d.pll_out = bus_in.wdata & adcoc_pkg::PLL_OUTPUT_PHASE_MASK;
			end else if (bus_in.addr == adcoc_pkg::USER_PATTERN_A_LOW_OFS) begin
				d.pat_a_low = bus_in.wdata;
			end else if (bus_in.addr == adcoc_pkg::USER_PATTERN_A_HIGH_OFS) begin
				d.pat_a_high = bus_in.wdata;
			end
		end
		// read data one cycle later, unmapped reads zero
		if (bus_in.rd) begin
			if (bus_in.addr == adcoc_pkg::DECIM_CLOCK_PHASE_CTRL_OFS) begin
				d.rdata = q.phase_ctrl;
			end else if (bus_in.addr == adcoc_pkg::LVDS_PAIR_POLARITY_OFS) begin
				d.rdata = q.polarity;
			end else if (bus_in.addr == adcoc_pkg::DIGITAL_OFFSET_LOW_OFS) begin
				d.rdata = q.offset_low;
			end else if (bus_in.addr == adcoc_pkg::DIGITAL_OFFSET_HIGH_OFS) begin
				d.rdata = q.offset_high;
			end else if (bus_in.addr == adcoc_pkg::OVERRANGE_WORDCLK_CTRL_OFS) begin
				d.rdata = q.flag_ctrl;
			end else if (bus_in.addr == adcoc_pkg::PLL_RECALIBRATION_OFS) begin
				d.rdata = q.recal;
			end else if (bus_in.addr == adcoc_pkg::PLL_OUTPUT_CLOCK_PHASE_OFS) begin
				d.rdata = q.pll_out;
			end else if (bus_in.addr == adcoc_pkg::USER_PATTERN_A_LOW_OFS) begin
				d.rdata = q.pat_a_low;
			end else if (bus_in.addr == adcoc_pkg::USER_PATTERN_A_HIGH_OFS) begin
				d.rdata = q.pat_a_high;
			end else if (bus_in.addr == adcoc_pkg::PLL_CAL_STATUS_OFS) begin
				d.rdata[adcoc_pkg::CAL_BUSY_BIT] = q.cal_busy;
			end
		end
		// toggle detect on every write to the recalibration register
		d.recal_pulse = wr_recal
			&& (bus_in.wdata[adcoc_pkg::RECAL_BIT] != q.recal[adcoc_pkg::RECAL_BIT]);
		// busy flag, a new start wins over done
		if (d.recal_pulse) begin
			d.cal_busy = 1'b1;
		end else if (pll_cal_done_in) begin
			d.cal_busy = 1'b0;
		end
		// sample path
		if (sample_valid_in) begin
			if (test_pattern_sel_in == adcoc_pkg::TEST_SEL_PATTERN_AB) begin
				d.data    = q.alt_sel ? pattern_b_in : pattern_a;
				d.alt_sel = !q.alt_sel;
			end else begin
				d.alt_sel = 1'b0;
				if (sum[17:13] == {5{sum[17]}}) begin
					d.data = sum[13:2];
				end else if (sum[17]) begin
					d.data = 12'h800;
				end else begin
					d.data = 12'h7FF;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q             <= '0;
			q.phase_ctrl  <= adcoc_pkg::DECIM_CLOCK_PHASE_CTRL_RST;
			q.polarity    <= adcoc_pkg::ZERO_RST;
			q.offset_low  <= adcoc_pkg::ZERO_RST;
			q.offset_high <= adcoc_pkg::ZERO_RST;
			q.flag_ctrl   <= adcoc_pkg::OVERRANGE_WORDCLK_CTRL_RST;
			q.recal       <= adcoc_pkg::PLL_RECALIBRATION_RST;
			q.pll_out     <= adcoc_pkg::ZERO_RST;
			q.pat_a_low   <= adcoc_pkg::ZERO_RST;
			q.pat_a_high  <= adcoc_pkg::ZERO_RST;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_recal_change;
		wr_recal && (bus_in.wdata[adcoc_pkg::RECAL_BIT] != q.recal[adcoc_pkg::RECAL_BIT]);
	endsequence
	sequence s_start_busy;
		synth_recal_pulse_out && pll_cal_busy_out;
	endsequence

	property p_recal_start;
		s_recal_change |=> s_start_busy;
	endproperty
	a_recal_start: assert property (p_recal_start) else $error("recal toggle gave no start");

	property p_recal_same;
		wr_recal && (bus_in.wdata[adcoc_pkg::RECAL_BIT] == q.recal[adcoc_pkg::RECAL_BIT]) |=> !synth_recal_pulse_out;
	endproperty
	a_recal_same: assert property (p_recal_same) else $error("unchanged recal bit started cal");

	property p_busy_read;
		pll_cal_busy_out && bus_in.rd && bus_in.addr == adcoc_pkg::PLL_CAL_STATUS_OFS
			|=> rdata_out[adcoc_pkg::CAL_BUSY_BIT];
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("status lost busy");

	property p_phase_off;
		!phase_delay_enable_out |-> decim_outclk_phase_sel_out == 3'h0;
	endproperty
	a_phase_off: assert property (p_phase_off) else $error("phase used while disabled");

	property p_phase_odd;
		phase_delay_enable_out && !decim_gt2 |-> decim_outclk_phase_sel_out[0];
	endproperty
	a_phase_odd: assert property (p_phase_odd) else $error("even shift in low decimation");

	property p_flag_en_wr;
		bus_in.wr && bus_in.addr == adcoc_pkg::OVERRANGE_WORDCLK_CTRL_OFS
			|=> flag_pair_enable_out == $past(bus_in.wdata[adcoc_pkg::FLAG_EN_BIT]);
	endproperty
	a_flag_en_wr: assert property (p_flag_en_wr) else $error("flag enable not written");

	property p_vco_max;
		pll_ready && decim_none && vco_code == 3'h7 |-> vco_cycle_outclk_delay_out == 4'hF;
	endproperty
	a_vco_max: assert property (p_vco_max) else $error("code 7 not fifteen cycles");

	property p_clk_gate;
		pll_clk_gate_out |-> pll_is_source_in && pll_enable_in && q.pll_out[adcoc_pkg::PLL_CLK_EN_BIT];
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("clock passed without conditions");

	property p_zero_offset;
		sample_valid_in && test_pattern_sel_in != adcoc_pkg::TEST_SEL_PATTERN_AB
			&& {q.offset_high, q.offset_low} == 16'h0000 |=> data_out == $past(sample_in);
	endproperty
	a_zero_offset: assert property (p_zero_offset) else $error("zero offset changed sample");

	property p_pattern_ab;
		sample_valid_in && test_pattern_sel_in == adcoc_pkg::TEST_SEL_PATTERN_AB && !q.alt_sel
			|=> data_out == $past(pattern_a);
	endproperty
	a_pattern_ab: assert property (p_pattern_ab) else $error("pattern A not shown");

	property p_pattern_b;
		sample_valid_in && test_pattern_sel_in == adcoc_pkg::TEST_SEL_PATTERN_AB && q.alt_sel
			|=> data_out == $past(pattern_b_in);
	endproperty
	a_pattern_b: assert property (p_pattern_b) else $error("pattern B not shown");

	sequence s_phase_on_write;
		bus_in.wr && bus_in.addr == adcoc_pkg::DECIM_CLOCK_PHASE_CTRL_OFS && bus_in.wdata[adcoc_pkg::PHASE_EN_BIT];
	endsequence

	property p_phase_en_wr;
		s_phase_on_write |=> phase_delay_enable_out;
	endproperty
	a_phase_en_wr: assert property (p_phase_en_wr) else $error("phase enable not written");

	property p_phase_pass;
		phase_delay_enable_out && decim_gt2 |-> decim_outclk_phase_sel_out == phase_code;
	endproperty
	a_phase_pass: assert property (p_phase_pass) else $error("phase code not passed");

	property p_phase_ref;
		phase_delay_enable_out && decim_gt2 && phase_code == 3'h0 |-> decim_outclk_phase_sel_out == 3'h0;
	endproperty
	a_phase_ref: assert property (p_phase_ref) else $error("reference phase moved");

	property p_pol_wr;
		bus_in.wr && bus_in.addr == adcoc_pkg::LVDS_PAIR_POLARITY_OFS
			|=> lvds_pair_invert_out == $past(bus_in.wdata[adcoc_pkg::POL_LSB +: 6]);
	endproperty
	a_pol_wr: assert property (p_pol_wr) else $error("pair invert not written");

	property p_flag_cmos;
		!lvds_mode_in |-> !flag_pair_invert_out;
	endproperty
	a_flag_cmos: assert property (p_flag_cmos) else $error("flag pair inverted outside lvds");

	property p_vco_off;
		!(pll_ready && decim_none) |-> vco_cycle_outclk_delay_out == 4'h0;
	endproperty
	a_vco_off: assert property (p_vco_off) else $error("vco delay without pll or with decimation");

	property p_vco_one;
		pll_ready && decim_none && vco_code == 3'h1 |-> vco_cycle_outclk_delay_out == 4'h1;
	endproperty
	a_vco_one: assert property (p_vco_one) else $error("code 1 not one cycle");

	property p_vco_fourteen;
		pll_ready && decim_none && vco_code == 3'h6 |-> vco_cycle_outclk_delay_out == 4'hE;
	endproperty
	a_vco_fourteen: assert property (p_vco_fourteen) else $error("code 6 not fourteen cycles");

	property p_gate_on;
		pll_ready && q.pll_out[adcoc_pkg::PLL_CLK_EN_BIT] |-> pll_clk_gate_out;
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("clock held although enabled");

	property p_pulse_once;
		synth_recal_pulse_out && !wr_recal |=> !synth_recal_pulse_out;
	endproperty
	a_pulse_once: assert property (p_pulse_once) else $error("recal pulse longer than one cycle");

	property p_busy_clear;
		pll_cal_done_in && !wr_recal |=> !pll_cal_busy_out;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared by done");

	property p_sat_high;
		sample_valid_in && test_pattern_sel_in != adcoc_pkg::TEST_SEL_PATTERN_AB
			&& !sum[17] && sum[17:13] != 5'h00 |=> data_out == 12'h7FF;
	endproperty
	a_sat_high: assert property (p_sat_high) else $error("positive overflow not clipped");

	property p_sat_low;
		sample_valid_in && test_pattern_sel_in != adcoc_pkg::TEST_SEL_PATTERN_AB
			&& sum[17] && sum[17:13] != 5'h1F |=> data_out == 12'h800;
	endproperty
	a_sat_low: assert property (p_sat_low) else $error("negative overflow not clipped");
endmodule : adcoc_regs
`default_nettype wire
